// ===== common/pmu_seq_pkg.sv
// Shared types and constants for the power state sequencer.
// Assumes a single 50 MHz clock domain.
package pmu_seq_pkg;

  localparam int CLK_HZ = 50000000;
  localparam int NUM_OUT = 7;
  localparam int NUM_BUCK = 4;
  localparam int NUM_FAULT = 4;
  localparam int DLY_W = 16;
  localparam int SS_W = 16;
  localparam int VSET_W = 8;
  localparam int TRIG_W = 4;

  // Retry wait in the output fault state
  localparam int RETRY_MS = 100;
  localparam int RETRY_CYCLES = RETRY_MS * (CLK_HZ / 1000);

  // Trigger select codes: 0..6 another output, 7 input power good, 8 external pin
  localparam logic [TRIG_W-1:0] TRIG_VIN = 4'h7;
  localparam logic [TRIG_W-1:0] TRIG_EXT = 4'h8;

  // Fault bit positions
  localparam int FLT_OV = 0;
  localparam int FLT_UV = 1;
  localparam int FLT_TSD = 2;
  localparam int FLT_OC = 3;

  // Sleep choices per output
  localparam logic [1:0] SLP_FIRST = 2'h0;
  localparam logic [1:0] SLP_SECOND = 2'h1;
  localparam logic [1:0] SLP_OFF = 2'h2;

  // Input range selections
  localparam logic [1:0] RANGE_3V3 = 2'h0;
  localparam logic [1:0] RANGE_5V = 2'h1;
  localparam logic [1:0] RANGE_WIDE = 2'h2;

  typedef enum logic [4:0] {
    ST_COLD    = 5'h01,
    ST_ACTIVE  = 5'h02,
    ST_SLEEP   = 5'h04,
    ST_THERMAL = 5'h08,
    ST_FAULT   = 5'h10
  } pstate_t;

  // Analog monitor inputs
  typedef struct packed {
    logic vin_uvlo;
    logic vin_in_window;
    logic over_temp;
    logic [NUM_OUT-1:0] out_ov;
    logic [NUM_OUT-1:0] out_uv;
    logic [NUM_OUT-1:0] out_oc;
    logic [NUM_OUT-1:0] out_pgood;
  } monitor_t;

  // Control and configuration bits from the register file
  typedef struct packed {
    logic sleep_control_mode;
    logic sleep_enable;
    logic sleep_entry_cmd;
    logic thermal_shutdown_enable;
    logic overvoltage_fault_enable;
    logic undervoltage_fault_enable;
    logic voltage_scaling_enable;
    logic input_level_select;
    logic wide_range_fixed;
    logic [NUM_FAULT-1:0] fault_mask;
  } control_t;

endpackage

// ===== design/out_channel.sv
// One regulator output channel: trigger, turn-on delay, soft start, on.
// Assumes trigger and enables are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module out_channel #(
  parameter int DLY_W = 16,
  parameter int SS_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic enable,
  input wire logic no_sequence,
  input wire logic trigger,
  input wire logic [DLY_W-1:0] turn_on_delay,
  input wire logic [SS_W-1:0] soft_start,
  // Status
  output logic on,
  output logic ramp_done
);
  typedef enum logic [3:0] {
    CH_OFF  = 4'h1,
    CH_WAIT = 4'h2,
    CH_RAMP = 4'h4,
    CH_ON   = 4'h8
  } ch_state_t;

  ch_state_t state;
  ch_state_t next_state;
  logic [DLY_W-1:0] dly_cnt;
  logic [DLY_W-1:0] next_dly_cnt;
  logic [SS_W-1:0] ss_cnt;
  logic [SS_W-1:0] next_ss_cnt;

  // Next channel state
  always_comb begin
    next_state = state;
    next_dly_cnt = dly_cnt;
    next_ss_cnt = ss_cnt;
    case (state)
      CH_OFF: begin
        next_dly_cnt = '0;
        next_ss_cnt = '0;
        if (enable && no_sequence) begin
          next_state = CH_RAMP;
        end else if (enable && trigger) begin
          next_state = CH_WAIT;
        end
      end
      CH_WAIT: begin
        if (dly_cnt >= turn_on_delay) begin
          next_state = CH_RAMP;
        end else begin
          next_dly_cnt = dly_cnt + 1'b1;
        end
      end
      CH_RAMP: begin
        if (ss_cnt >= soft_start) begin
          next_state = CH_ON;
        end else begin
          next_ss_cnt = ss_cnt + 1'b1;
        end
      end
      CH_ON: next_state = CH_ON;
      default: next_state = CH_OFF;
    endcase
    if (!enable) begin
      next_state = CH_OFF;
    end
  end

  // Register channel state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= CH_OFF;
      dly_cnt <= '0;
      ss_cnt <= '0;
    end else begin
      state <= next_state;
      dly_cnt <= next_dly_cnt;
      ss_cnt <= next_ss_cnt;
    end
  end

  assign on = (state == CH_RAMP) || (state == CH_ON);
  assign ramp_done = (state == CH_ON);
endmodule // out_channel
`default_nettype wire

// ===== design/pmu_power_sequencer.sv
// Top level power state machine, sequencing, voltage selection and faults.
// Assumes all inputs are synchronous to clk; the serial port lives outside.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Cold reset: regulators off, resets low
// - Cold reset restores volatile and programmed defaults
// - Leave cold reset when input in window
// - Input below lockout forces cold reset
// - Sequence from cold reset, not from sleep
// - Sleep follows per-output setpoint or off choice
// - Sleep transitions unordered but soft-started
// - Serial port off in sleep; pin wakes
// - Overtemperature enters thermal state, all off
// - Thermal enable gates entry; flag stays live
// - Output OV, or UV after ramp, faults
// - Retry active after 100 ms, forever
// - OV/UV enable bits gate fault entry
// - Overcurrent alone never enters fault state
// - Turn-on delay counted from trigger
// - Output waits for its assigned trigger
// - Bucks use first setpoint, second when chosen
// - Input range from wide and level bits
// - Flags live; unmasked faults set sticky bits
// - Interrupt releases after clear and read
// - Serial logic reset outside active, including sleep
// - Mode zero: pin moves sleep and active
module pmu_power_sequencer
  import pmu_seq_pkg::*;
#(
  parameter int RETRY_COUNT = RETRY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Monitors and pins
  input wire pmu_seq_pkg::monitor_t mon,
  input wire logic sleep_control_pin,
  input wire logic external_power_good_pin,
  // Configuration
  input wire pmu_seq_pkg::control_t ctrl,
  input wire logic [pmu_seq_pkg::NUM_OUT*pmu_seq_pkg::TRIG_W-1:0] trigger_select,
  input wire logic [pmu_seq_pkg::NUM_OUT*pmu_seq_pkg::DLY_W-1:0] turn_on_delay,
  input wire logic [pmu_seq_pkg::NUM_OUT*pmu_seq_pkg::SS_W-1:0] soft_start,
  input wire logic [pmu_seq_pkg::NUM_OUT*2-1:0] sleep_choice,
  input wire logic [pmu_seq_pkg::NUM_BUCK*pmu_seq_pkg::VSET_W-1:0] buck_first_setpoint,
  input wire logic [pmu_seq_pkg::NUM_BUCK*pmu_seq_pkg::VSET_W-1:0] buck_second_setpoint,
  input wire logic fault_read,
  // Outputs
  output logic [pmu_seq_pkg::NUM_OUT-1:0] regulator_enable,
  output logic [pmu_seq_pkg::NUM_BUCK*pmu_seq_pkg::VSET_W-1:0] buck_target,
  output logic main_reset_out_n,
  output logic aux_reset_out_a_n,
  output logic aux_reset_out_b_n,
  output logic serial_reset_n,
  output logic defaults_load,
  output logic [1:0] input_range,
  output logic thermal_shutdown_flag,
  output logic [pmu_seq_pkg::NUM_FAULT-1:0] fault_flags,
  output logic [pmu_seq_pkg::NUM_FAULT-1:0] fault_bits,
  output logic irq_n,
  output var pmu_seq_pkg::pstate_t power_state
);
  import pmu_seq_pkg::*;

  pstate_t state;
  pstate_t next_state;
  logic [31:0] retry_cnt;
  logic [31:0] next_retry_cnt;
  logic sleep_pin_q;
  logic next_sleep_pin_q;
  logic from_sleep;
  logic next_from_sleep;
  logic [NUM_OUT-1:0] ch_on;
  logic [NUM_OUT-1:0] ch_done;
  logic [NUM_OUT-1:0] ch_enable;
  logic [NUM_OUT-1:0] ch_trigger;
  logic [NUM_OUT-1:0] next_reg_en;
  logic [NUM_BUCK*VSET_W-1:0] next_target;
  logic [NUM_FAULT-1:0] next_flags;
  logic [NUM_FAULT-1:0] next_fault_bits;
  logic [1:0] next_range;
  logic ov_hit;
  logic uv_hit;
  logic tsd_hit;
  logic pin_edge;
  logic outs_off;

  // Fault, thermal and sleep entry conditions, and outputs-off decode
  always_comb begin
    ov_hit = ctrl.overvoltage_fault_enable && (|(mon.out_ov & ch_on));
    uv_hit = ctrl.undervoltage_fault_enable && (|(mon.out_uv & ch_done));
    tsd_hit = ctrl.thermal_shutdown_enable && mon.over_temp;
    pin_edge = sleep_control_pin != sleep_pin_q;
    outs_off = (state != ST_ACTIVE) && (state != ST_SLEEP);
  end

  // Next power state
  always_comb begin
    next_state = state;
    next_retry_cnt = '0;
    next_from_sleep = from_sleep;
    next_sleep_pin_q = sleep_control_pin;
    case (state)
      ST_COLD: begin
        next_from_sleep = 1'b0;
        if (mon.vin_in_window && !mon.vin_uvlo) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (tsd_hit) begin
          next_state = ST_THERMAL;
        end else if (ov_hit || uv_hit) begin
          next_state = ST_FAULT;
        end else if (ctrl.sleep_enable && !ctrl.sleep_control_mode && pin_edge) begin
          next_state = ST_SLEEP;
        end else if (ctrl.sleep_enable && ctrl.sleep_control_mode && ctrl.sleep_entry_cmd) begin
          next_state = ST_SLEEP;
        end
        if (next_state == ST_SLEEP) begin
          next_from_sleep = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (tsd_hit) begin
          next_state = ST_THERMAL;
        end else if (ov_hit || uv_hit) begin
          next_state = ST_FAULT;
        end else if (pin_edge) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_THERMAL: begin
        next_from_sleep = 1'b0;
        if (!mon.over_temp || !ctrl.thermal_shutdown_enable) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_FAULT: begin
        next_from_sleep = 1'b0;
        if (retry_cnt >= 32'(RETRY_COUNT - 1)) begin
          next_state = ST_ACTIVE;
        end else begin
          next_retry_cnt = retry_cnt + 32'h00000001;
        end
      end
      default: next_state = ST_COLD;
    endcase
    if (mon.vin_uvlo) begin
      next_state = ST_COLD;
    end
  end

  // Register power state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= ST_COLD;
      retry_cnt <= '0;
      from_sleep <= 1'b0;
      sleep_pin_q <= 1'b0;
    end else begin
      state <= next_state;
      retry_cnt <= next_retry_cnt;
      from_sleep <= next_from_sleep;
      sleep_pin_q <= next_sleep_pin_q;
    end
  end

  // Per-output enable and trigger selection
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      logic [TRIG_W-1:0] sel;
      logic [1:0] choice;
      sel = trigger_select[i*TRIG_W +: TRIG_W];
      choice = sleep_choice[i*2 +: 2];
      if (sel == TRIG_VIN) begin
        ch_trigger[i] = mon.vin_in_window;
      end else if (sel == TRIG_EXT) begin
        ch_trigger[i] = external_power_good_pin;
      end else if (sel < TRIG_W'(NUM_OUT)) begin
        ch_trigger[i] = mon.out_pgood[sel[2:0]];
      end else begin
        ch_trigger[i] = 1'b0;
      end
      if (state == ST_SLEEP) begin
        ch_enable[i] = (choice != SLP_OFF);
      end else begin
        ch_enable[i] = (state == ST_ACTIVE);
      end
    end
  end

  // One channel per regulator output
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_ch
    out_channel #(
      .DLY_W(DLY_W),
      .SS_W(SS_W)
    ) u_ch (
      .clk(clk),
      .nrst(nrst),
      .enable(ch_enable[g]),
      .no_sequence(from_sleep),
      .trigger(ch_trigger[g]),
      .turn_on_delay(turn_on_delay[g*DLY_W +: DLY_W]),
      .soft_start(soft_start[g*SS_W +: SS_W]),
      .on(ch_on[g]),
      .ramp_done(ch_done[g])
    );
  end

  // Output enables, setpoints, range and faults
  always_comb begin
    next_reg_en = outs_off ? '0 : ch_on;
    for (int b = 0; b < NUM_BUCK; b++) begin
      logic use_second;
      use_second = 1'b0;
      if (state == ST_SLEEP) begin
        use_second = (sleep_choice[b*2 +: 2] == SLP_SECOND);
      end else if (state == ST_ACTIVE && ctrl.voltage_scaling_enable) begin
        use_second = external_power_good_pin;
      end
      next_target[b*VSET_W +: VSET_W] = use_second ?
        buck_second_setpoint[b*VSET_W +: VSET_W] :
        buck_first_setpoint[b*VSET_W +: VSET_W];
    end
    if (ctrl.wide_range_fixed) begin
      next_range = RANGE_WIDE;
    end else if (ctrl.input_level_select) begin
      next_range = RANGE_5V;
    end else begin
      next_range = RANGE_3V3;
    end
    next_flags = '0;
    next_flags[FLT_OV] = |(mon.out_ov & ch_on);
    next_flags[FLT_UV] = |(mon.out_uv & ch_done);
    next_flags[FLT_TSD] = mon.over_temp;
    next_flags[FLT_OC] = |(mon.out_oc & ch_on);
    // Set wins over read; read clears only cleared conditions
    next_fault_bits = fault_read ? (fault_bits & next_flags) : fault_bits;
    next_fault_bits = next_fault_bits | (next_flags & ~ctrl.fault_mask);
  end

  // Register outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      regulator_enable <= '0;
      buck_target <= '0;
      main_reset_out_n <= 1'b0;
      aux_reset_out_a_n <= 1'b0;
      aux_reset_out_b_n <= 1'b0;
      serial_reset_n <= 1'b0;
      defaults_load <= 1'b1;
      input_range <= RANGE_3V3;
      thermal_shutdown_flag <= 1'b0;
      fault_flags <= '0;
      fault_bits <= '0;
      irq_n <= 1'b1;
      power_state <= ST_COLD;
    end else begin
      regulator_enable <= next_reg_en;
      buck_target <= next_target;
      main_reset_out_n <= !outs_off && (&ch_done);
      aux_reset_out_a_n <= !outs_off && (&ch_done);
      aux_reset_out_b_n <= !outs_off && (&ch_done);
      serial_reset_n <= (state == ST_ACTIVE);
      defaults_load <= (state == ST_COLD);
      input_range <= next_range;
      thermal_shutdown_flag <= mon.over_temp;
      fault_flags <= next_flags;
      fault_bits <= next_fault_bits;
      irq_n <= ~(|next_fault_bits);
      power_state <= state;
    end
  end
endmodule // pmu_power_sequencer
`default_nettype wire

// ===== testbench/pmu_seq_chk.sv
// Port checker for the power state sequencer.
// Bound to every sequencer instance; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pmu_seq_chk #(
  parameter int RETRY_COUNT = pmu_seq_pkg::RETRY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Inputs seen by the design
  input wire pmu_seq_pkg::monitor_t mon,
  input wire pmu_seq_pkg::control_t ctrl,
  input wire logic fault_read,
  // Design outputs
  input wire logic [pmu_seq_pkg::NUM_OUT-1:0] regulator_enable,
  input wire logic main_reset_out_n,
  input wire logic aux_reset_out_a_n,
  input wire logic aux_reset_out_b_n,
  input wire logic serial_reset_n,
  input wire logic [1:0] input_range,
  input wire logic [pmu_seq_pkg::NUM_FAULT-1:0] fault_flags,
  input wire logic [pmu_seq_pkg::NUM_FAULT-1:0] fault_bits,
  input wire logic irq_n,
  input wire pmu_seq_pkg::pstate_t power_state
);
  import pmu_seq_pkg::*;
  logic [31:0] dwell;
  logic [31:0] next_dwell;
  logic cause;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Dwell counter in the fault state and the enabled fault cause
  always_comb begin
    next_dwell = (power_state == ST_FAULT) ? dwell + 32'h1 : 32'h0;
    cause = (mon.out_ov != '0 && ctrl.overvoltage_fault_enable) ||
            (mon.out_uv != '0 && ctrl.undervoltage_fault_enable);
  end
  always_ff @(posedge clk) begin
    dwell <= nrst ? next_dwell : 32'h0;
  end
  sequence s_fault_in;
    $rose(power_state == ST_FAULT);
  endsequence
  sequence s_fault_out;
    $fell(power_state == ST_FAULT) && !$past(mon.vin_uvlo, 2);
  endsequence
  property p_off;
    (power_state inside {ST_COLD, ST_THERMAL, ST_FAULT}) && (power_state == $past(power_state))
      |-> regulator_enable == '0 && !main_reset_out_n && !aux_reset_out_a_n && !aux_reset_out_b_n;
  endproperty
  property p_uvlo;
    mon.vin_uvlo |-> ##[1:3] power_state == ST_COLD;
  endproperty
  property p_therm;
    $rose(power_state == ST_THERMAL)
      |-> $past(ctrl.thermal_shutdown_enable, 2) && $past(mon.over_temp, 2);
  endproperty
  property p_cause;
    s_fault_in |-> $past(cause, 2);
  endproperty
  property p_retry_min;
    s_fault_out |-> dwell >= RETRY_COUNT - 1;
  endproperty
  property p_retry_max;
    dwell <= RETRY_COUNT + 1;
  endproperty
  property p_irq;
    (fault_flags & ~$past(ctrl.fault_mask)) != '0 |-> !irq_n;
  endproperty
  property p_clear;
    ($past(fault_bits) & ~fault_bits) != '0 |-> $past(fault_read);
  endproperty
  property p_range;
    $past(nrst) |-> input_range == ($past(ctrl.wide_range_fixed) ? RANGE_WIDE :
      ($past(ctrl.input_level_select) ? RANGE_5V : RANGE_3V3));
  endproperty
  property p_serial;
    power_state != ST_ACTIVE && $past(power_state) != ST_ACTIVE |-> !serial_reset_n;
  endproperty
  a_off: assert property (p_off) else $error("outputs on in shutdown state");
  a_uvlo: assert property (p_uvlo) else $error("no cold state on lockout");
  a_therm: assert property (p_therm) else $error("thermal entry without cause");
  a_cause: assert property (p_cause) else $error("fault entry without cause");
  a_retry_min: assert property (p_retry_min) else $error("retry too early");
  a_retry_max: assert property (p_retry_max) else $error("retry too late");
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  a_clear: assert property (p_clear) else $error("fault bit cleared unread");
  a_range: assert property (p_range) else $error("wrong input range");
  a_serial: assert property (p_serial) else $error("serial logic not held");
endmodule // pmu_seq_chk
bind pmu_power_sequencer pmu_seq_chk #(.RETRY_COUNT(RETRY_COUNT)) chk_u (
  .clk(clk), .nrst(nrst), .mon(mon), .ctrl(ctrl), .fault_read(fault_read),
  .regulator_enable(regulator_enable), .main_reset_out_n(main_reset_out_n),
  .aux_reset_out_a_n(aux_reset_out_a_n), .aux_reset_out_b_n(aux_reset_out_b_n),
  .serial_reset_n(serial_reset_n), .input_range(input_range), .fault_flags(fault_flags),
  .fault_bits(fault_bits), .irq_n(irq_n), .power_state(power_state)
);
`default_nettype wire

// ===== testbench/host_pins.sv
// Host side pin model: sleep pin, external power good and fault reads.
// Driven from the bench through its tasks; changes land at falling clock.
`timescale 1ns/1ps
`default_nettype none
module host_pins (
  // Clock
  input wire logic clk,
  // Pins toward the device
  output logic sleep_control_pin,
  output logic external_power_good_pin,
  output logic fault_read
);
  // Idle levels from time zero
  initial begin
    sleep_control_pin = 1'b0;
    external_power_good_pin = 1'b0;
    fault_read = 1'b0;
  end
  // An edge of the pin is a wake request, or a sleep request in mode zero
  task automatic tog();
    @(negedge clk);
    sleep_control_pin = ~sleep_control_pin;
  endtask
  // Power good or scaling select level
  task automatic pg(input logic v);
    @(negedge clk);
    external_power_good_pin = v;
  endtask
  // One cycle read of the fault bits
  task automatic rd();
    @(negedge clk);
    fault_read = 1'b1;
    @(negedge clk);
    fault_read = 1'b0;
  endtask
endmodule // host_pins
`default_nettype wire

// ===== testbench/pmu_power_sequencer_tb.sv
// Self-checking bench for the power state sequencer.
// Host pins come from host_pins; monitors and controls from here.
`timescale 1ns/1ps
`default_nettype none
module pmu_power_sequencer_tb;
  import pmu_seq_pkg::*;
  localparam int RETRY = 20;
  localparam logic [31:0] V0 = 32'h11223344;
  localparam logic [31:0] V1 = 32'hA1B2C3D4;
  logic clk = 1'b0;
  logic nrst;
  monitor_t mon;
  control_t ctrl;
  logic [NUM_OUT*TRIG_W-1:0] trig;
  logic [NUM_OUT*DLY_W-1:0] dly;
  logic [NUM_OUT*SS_W-1:0] ss;
  logic [NUM_OUT*2-1:0] slp;
  logic [NUM_OUT-1:0] en;
  logic [31:0] tgt;
  logic [31:0] vs0 = V0;
  logic [31:0] vs1 = V1;
  logic rst_m, rst_a, rst_b, ser_n, dflt, tsd, irq_n, pin, epg, frd;
  logic [1:0] rng;
  logic [NUM_FAULT-1:0] flags, bits;
  pstate_t st;
  int n_fail = 0;
  int tests_run = 0;
  int k;
  int cnt;
  // Clock
  always #10 clk = ~clk;
  host_pins host_u (.clk(clk), .sleep_control_pin(pin), .external_power_good_pin(epg),
    .fault_read(frd));
  pmu_power_sequencer #(.RETRY_COUNT(RETRY)) dut_u (.clk(clk), .nrst(nrst), .mon(mon),
    .sleep_control_pin(pin), .external_power_good_pin(epg), .ctrl(ctrl), .trigger_select(trig),
    .turn_on_delay(dly), .soft_start(ss), .sleep_choice(slp), .buck_first_setpoint(vs0),
    .buck_second_setpoint(vs1), .fault_read(frd), .regulator_enable(en), .buck_target(tgt),
    .main_reset_out_n(rst_m), .aux_reset_out_a_n(rst_a), .aux_reset_out_b_n(rst_b),
    .serial_reset_n(ser_n), .defaults_load(dflt), .input_range(rng),
    .thermal_shutdown_flag(tsd), .fault_flags(flags), .fault_bits(bits), .irq_n(irq_n),
    .power_state(st));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wait_st(input pstate_t s, input int n);
    int i;
    for (i = 0; i < n && st !== s; i++) cyc(1);
    chk("state", 32'(s), 32'(st));
  endtask
  task automatic wait_en(input logic [6:0] e);
    int i;
    for (i = 0; i < 60 && en !== e; i++) cyc(1);
    chk("enable", 32'(e), 32'(en));
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    mon = '0;
    ctrl = '0;
    ctrl.thermal_shutdown_enable = 1'b1;
    ctrl.overvoltage_fault_enable = 1'b1;
    ctrl.undervoltage_fault_enable = 1'b1;
    ctrl.fault_mask = 4'h8;
    trig = {TRIG_EXT, 4'h0, {5{TRIG_VIN}}};
    dly = {7{16'h0010}};
    ss = {7{16'h0003}};
    slp = {SLP_OFF, SLP_FIRST, SLP_FIRST, {4{SLP_SECOND}}};
    cyc(20);
    nrst = 1'b1;
    cyc(1);
    chk("off", 32'h0, 32'({en, rst_m, rst_a, rst_b}));
    chk("defaults", 32'h1, 32'(dflt));
    cyc(5);
    chk("cold", 32'(ST_COLD), 32'(st));
    mon.vin_in_window = 1'b1;
    wait_st(ST_ACTIVE, 5);
    chk("delay", 32'h0, 32'(en));
    wait_en(7'h1F);
    chk("resets", 32'h0, 32'({rst_m, rst_a, rst_b}));
    mon.out_pgood[0] = 1'b1;
    wait_en(7'h3F);
    host_u.pg(1'b1);
    wait_en(7'h7F);
    cyc(8);
    chk("resets", 32'h7, 32'({rst_m, rst_a, rst_b}));
    chk("serial", 32'h1, 32'(ser_n));
    chk("target", V0, tgt);
    ctrl.voltage_scaling_enable = 1'b1;
    cyc(3);
    chk("target", V1, tgt);
    chk("state", 32'(ST_ACTIVE), 32'(st));
    host_u.pg(1'b0);
    cyc(3);
    chk("target", V0, tgt);
    vs0 = 32'h55667788;
    cyc(2);
    chk("target", 32'h55667788, tgt);
    vs0 = V0;
    ctrl.voltage_scaling_enable = 1'b0;
    host_u.pg(1'b1);
    for (k = 0; k < 4; k++) begin
      {ctrl.wide_range_fixed, ctrl.input_level_select} = 2'(k);
      cyc(2);
      chk("range", k[1] ? 32'(RANGE_WIDE) : 32'(k), 32'(rng));
    end
    mon.out_oc[0] = 1'b1;
    cyc(5);
    chk("state", 32'(ST_ACTIVE), 32'(st));
    chk("flags", 32'h8, 32'(flags));
    chk("bits", 32'h0, 32'(bits));
    mon.out_oc[0] = 1'b0;
    ctrl.thermal_shutdown_enable = 1'b0;
    mon.over_temp = 1'b1;
    cyc(5);
    chk("state", 32'(ST_ACTIVE), 32'(st));
    chk("tsd flag", 32'h1, 32'(tsd));
    host_u.rd();
    cyc(3);
    chk("irq", 32'h0, 32'(irq_n));
    mon.over_temp = 1'b0;
    cyc(3);
    chk("irq", 32'h0, 32'(irq_n));
    host_u.rd();
    cyc(3);
    chk("irq", 32'h1, 32'(irq_n));
    ctrl.thermal_shutdown_enable = 1'b1;
    mon.over_temp = 1'b1;
    wait_st(ST_THERMAL, 5);
    cyc(2);
    chk("off", 32'h0, 32'({en, rst_m, rst_a, rst_b}));
    mon.over_temp = 1'b0;
    mon.out_uv[3] = 1'b1;
    wait_st(ST_ACTIVE, 5);
    wait_en(7'h7F);
    chk("state", 32'(ST_ACTIVE), 32'(st));
    wait_st(ST_FAULT, 10);
    mon.out_uv[3] = 1'b0;
    wait_st(ST_ACTIVE, RETRY + 5);
    wait_en(7'h7F);
    ctrl.overvoltage_fault_enable = 1'b0;
    mon.out_ov[2] = 1'b1;
    cyc(5);
    chk("state", 32'(ST_ACTIVE), 32'(st));
    ctrl.overvoltage_fault_enable = 1'b1;
    wait_st(ST_FAULT, 5);
    cyc(2);
    chk("off", 32'h0, 32'({en, rst_m, rst_a, rst_b}));
    wait_st(ST_ACTIVE, RETRY + 5);
    wait_st(ST_FAULT, 40);
    mon.out_ov[2] = 1'b0;
    cnt = 0;
    while (st === ST_FAULT && cnt < 200) begin
      cyc(1);
      cnt++;
    end
    chk("retry", 32'h1, 32'(cnt >= RETRY - 2 && cnt <= RETRY + 2));
    wait_en(7'h7F);
    ctrl.sleep_control_mode = 1'b1;
    ctrl.sleep_enable = 1'b1;
    cyc(1);
    ctrl.sleep_entry_cmd = 1'b1;
    wait_st(ST_SLEEP, 5);
    ctrl.sleep_entry_cmd = 1'b0;
    cyc(8);
    chk("sleep en", 32'h3F, 32'(en));
    chk("target", V1, tgt);
    chk("serial", 32'h0, 32'(ser_n));
    host_u.tog();
    wait_st(ST_ACTIVE, 5);
    cyc(6);
    chk("wake en", 32'h7F, 32'(en));
    ctrl.sleep_control_mode = 1'b0;
    host_u.tog();
    wait_st(ST_SLEEP, 5);
    host_u.tog();
    wait_st(ST_ACTIVE, 5);
    mon.vin_uvlo = 1'b1;
    wait_st(ST_COLD, 5);
    cyc(2);
    chk("off", 32'h0, 32'({en, rst_m, rst_a, rst_b}));
    chk("defaults", 32'h1, 32'(dflt));
    final_report();
  end
  // Watchdog against a hang
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
endmodule // pmu_power_sequencer_tb
`default_nettype wire
